// File: sim/dag_address_gen_properties.sv
module dag_address_gen_properties
  import dag_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire logic o_req_ready,
  input wire logic [7:0] i_file_op,
  input wire logic i_acc_sel,
  input wire logic i_req_write,
  input wire logic [7:0] i_req_wdata,
  input wire logic o_done,
  input wire logic [7:0] o_rdata,
  input wire logic [11:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic o_pslverr
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Taken request, memory strobe, virtual operand address
  logic take;
  logic strobe;
  logic virt;
  assign take = i_req_valid && o_req_ready;
  assign strobe = o_mem_rd || o_mem_wr;
  assign virt = o_mem_addr inside {[12'hFDB:12'hFDF], [12'hFE3:12'hFE7], [12'hFEB:12'hFEF]};

  answer_time_a: assert property (take |=> !o_req_ready ##1 !o_req_ready ##1 o_done)
    else $error("answer not on third cycle");
  one_strobe_a: assert property (strobe |=> !strobe)
    else $error("strobe longer than one cycle");
  strobe_cause_a: assert property (strobe |-> $past(take))
    else $error("strobe without request");
  no_virtual_a: assert property (strobe |-> !virt)
    else $error("virtual operand reached memory");
  forced_page_a: assert property (take && !i_acc_sel && i_file_op >= 8'h60
    && !(i_file_op inside {[8'hDB:8'hDF], [8'hE3:8'hE7], [8'hEB:8'hEF]})
    |=> !strobe || o_mem_addr == {4'hF, $past(i_file_op)})
    else $error("forced page address wrong");
  read_data_a: assert property (o_mem_rd |=> ##1 (o_done && o_rdata == $past(i_mem_rdata)))
    else $error("read data not passed on");
  write_data_a: assert property (take && i_req_write
    |=> !o_mem_rd && (!o_mem_wr || o_mem_wdata == $past(i_req_wdata)))
    else $error("write data wrong");
  read_only_a: assert property (take && !i_req_write |=> !o_mem_wr)
    else $error("read caused a write");
  apb_error_a: assert property (i_psel && i_penable
    |-> o_pslverr == !(i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
    else $error("slave error flag wrong");

  // Main scenarios reached
  cover property (take && i_req_write);
  cover property (take && !i_acc_sel && i_file_op <= DAG_LITOFF_MAX);
  cover property (o_mem_rd);
endmodule : dag_address_gen_properties

bind dag_address_gen dag_address_gen_properties u_props (
  .i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst),
  .i_req_valid(i_req_valid),
  .o_req_ready(o_req_ready),
  .i_file_op(i_file_op),
  .i_acc_sel(i_acc_sel),
  .i_req_write(i_req_write),
  .i_req_wdata(i_req_wdata),
  .o_done(o_done),
  .o_rdata(o_rdata),
  .o_mem_addr(o_mem_addr),
  .o_mem_rd(o_mem_rd),
  .o_mem_wr(o_mem_wr),
  .o_mem_wdata(o_mem_wdata),
  .i_mem_rdata(i_mem_rdata),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_paddr(i_paddr),
  .o_pslverr(o_pslverr)
);

// File: sim/dag_address_gen_tb.sv
module dag_address_gen_tb
  import dag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0, i_acc_sel = 1'b0;
  logic i_req_write = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_file_op = 8'h00, i_req_wdata = 8'h00, i_w_reg = 8'h00, i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, r_seen;
  logic o_req_ready, o_done, o_mem_rd, o_mem_wr, o_pready, o_pslverr, e_seen;
  logic [7:0] o_rdata, o_mem_wdata, i_mem_rdata, d_seen;
  logic [11:0] o_mem_addr, a_seen;
  logic [1:0] s_seen;
  int n_errors = 0;
  int checked = 0;

  dag_address_gen uut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_file_op(i_file_op), .i_acc_sel(i_acc_sel), .i_req_write(i_req_write),
    .i_req_wdata(i_req_wdata), .i_w_reg(i_w_reg), .o_done(o_done), .o_rdata(o_rdata),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr));
  dag_mem_model mem (.i_sys_clk(i_sys_clk), .i_addr(o_mem_addr), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

  // Clock and hang guard
  initial forever #5 i_sys_clk = ~i_sys_clk;
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction : pat

  // One APB transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    r_seen = o_prdata;
    e_seen = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic get(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register", r_seen, exp);
  endtask : get

  // Core request; strobes sampled one cycle after the take, answer two later
  task automatic core(input logic w, a, input logic [7:0] f, d, x);
    @(posedge i_sys_clk);
    i_req_valid <= 1'b1;
    i_req_write <= w;
    i_acc_sel <= a;
    i_file_op <= f;
    i_req_wdata <= d;
    i_w_reg <= x;
    @(posedge i_sys_clk);
    i_req_valid <= 1'b0;
    @(negedge i_sys_clk);
    a_seen = o_mem_addr;
    s_seen = {o_mem_rd, o_mem_wr};
    repeat (2) @(negedge i_sys_clk);
    chk("done", o_done, 1);
    d_seen = o_rdata;
  endtask : core

  task automatic rd_at(input logic a, input logic [7:0] f, x, input logic [11:0] exp);
    core(1'b0, a, f, 8'h00, x);
    chk("address", a_seen, exp);
    chk("strobe", s_seen, 2'b10);
    chk("read data", d_seen, pat(exp));
  endtask : rd_at

  task automatic t_reset();
    for (int i = 0; i <= 16; i += 4) begin
      get(8'(i), 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("slave error", e_seen, 1);
  endtask : t_reset

  // Carry and borrow across the low byte
  task automatic t_step();
    apb(1'b1, DAG_OFS_PTR0, 32'h0FF);
    rd_at(1'b0, 8'hEE, 8'h00, 12'h0FF);
    get(DAG_OFS_PTR0, 32'h100);
    rd_at(1'b0, 8'hED, 8'h00, 12'h100);
    get(DAG_OFS_PTR0, 32'h0FF);
    rd_at(1'b0, 8'hEC, 8'h00, 12'h100);
    core(1'b1, 1'b0, 8'hEE, 8'h5A, 8'h00);
    chk("write strobe", s_seen, 2'b01);
    get(DAG_OFS_PTR0, 32'h101);
  endtask : t_step

  task automatic t_index();
    apb(1'b1, DAG_OFS_PTR1, 32'h005);
    rd_at(1'b0, 8'hE3, 8'hFE, 12'h003);
    rd_at(1'b0, 8'hE3, 8'h80, 12'hF85);
    apb(1'b1, DAG_OFS_PTR1, 32'hFF0);
    rd_at(1'b0, 8'hE3, 8'h7F, 12'h06F);
    rd_at(1'b0, 8'hE7, 8'h00, 12'hFF0);
    get(DAG_OFS_PTR1, 32'hFF0);
  endtask : t_index

  // Pointer aimed at a virtual operand, then at its own byte
  task automatic t_dead();
    apb(1'b1, DAG_OFS_PTR0, 32'hFE7);
    apb(1'b1, DAG_OFS_PTR1, 32'h234);
    core(1'b0, 1'b0, 8'hEF, 8'h00, 8'h00);
    chk("dead read", {s_seen, d_seen}, 10'h000);
    get(DAG_OFS_STATUS, 32'h0001_4FE7);
    core(1'b1, 1'b0, 8'hEF, 8'h55, 8'h00);
    chk("dead write", s_seen, 2'b00);
    get(DAG_OFS_PTR1, 32'h234);
    apb(1'b1, DAG_OFS_PTR2, 32'hFD9);
    core(1'b1, 1'b0, 8'hDD, 8'h45, 8'h00);
    get(DAG_OFS_PTR2, 32'hF45);
    core(1'b1, 1'b0, 8'hEA, 8'hA3, 8'h00);
    get(DAG_OFS_PTR0, 32'h3E7);
    core(1'b0, 1'b0, 8'hE9, 8'h00, 8'h00);
    chk("pointer byte", d_seen, 8'hE7);
  endtask : t_dead

  task automatic t_ext();
    apb(1'b1, DAG_OFS_CTRL, 32'h1);
    apb(1'b1, DAG_OFS_PTR2, 32'h200);
    apb(1'b1, DAG_OFS_BANK, 32'h3);
    apb(1'b1, DAG_OFS_PTR0, 32'h050);
    rd_at(1'b0, 8'h5F, 8'h00, 12'h25F);
    get(DAG_OFS_STATUS, 32'h0000_C25F);
    rd_at(1'b0, 8'h60, 8'h00, 12'hF60);
    rd_at(1'b1, 8'h10, 8'h00, 12'h310);
    rd_at(1'b0, 8'hEF, 8'h00, 12'h050);
    rd_at(1'b0, 8'hDF, 8'h00, 12'h200);
    apb(1'b1, DAG_OFS_PTR2, 32'hFF0);
    rd_at(1'b0, 8'h20, 8'h00, 12'h010);
    apb(1'b1, DAG_OFS_CTRL, 32'h0);
    rd_at(1'b0, 8'h5F, 8'h00, 12'h05F);
    rd_at(1'b1, 8'h10, 8'h00, 12'h310);
  endtask : t_ext

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_step();
    t_index();
    t_dead();
    t_ext();
    give_verdict();
  end
endmodule : dag_address_gen_tb

// File: sim/dag_mem_model.sv
module dag_mem_model (
  input wire logic i_sys_clk,
  input wire logic [11:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4096];

  // Distinct pattern so a wrong address shows up in the data
  initial begin
    o_rdata = 8'h00;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ {i[11:8], i[11:8]};
    end
  end

  // Data valid only after a read strobe; otherwise it keeps changing
  always @(posedge i_sys_clk) begin
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
  end
endmodule : dag_mem_model

// File: verilog/dag_address_gen.sv
// Design decision made here: register access over APB.
module dag_address_gen
  import dag_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Core request port
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [7:0] i_file_op,
  input wire logic i_acc_sel,
  input wire logic i_req_write,
  input wire logic [7:0] i_req_wdata,
  input wire logic [7:0] i_w_reg,
  output logic o_done,
  output logic [7:0] o_rdata,
  // Data memory port
  output logic [11:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);

  logic [11:0] ptr_reg [DAG_NPTR];
  logic [11:0] ptr_next [DAG_NPTR];
  logic [3:0] bank_reg;
  logic xset_reg;
  dag_state_t state_reg;
  dag_mode_t mode_reg;
  logic [11:0] last_addr_reg;
  logic rd_src_mem_reg;
  logic [7:0] rd_local_reg;

  logic take;
  logic [11:0] dir_addr;
  dag_mode_t dir_mode;
  logic dir_virt;
  logic [1:0] dir_pair;
  logic [2:0] dir_vop;
  logic [11:0] eff_addr;
  dag_mode_t eff_mode;
  logic eff_null;
  logic [7:0] loc_rdata;
  logic loc_hit;
  logic [11:0] sw_w;

  // Virtual operand lookup: which pair and which operand kind
  function automatic logic vop_lookup(input logic [11:0] a, output logic [1:0] p, output logic [2:0] k);
    logic [11:0] d0;
    logic [11:0] d1;
    logic [11:0] d2;
    d0 = a - DAG_VIRT0_BASE;
    d1 = a - DAG_VIRT1_BASE;
    d2 = a - DAG_VIRT2_BASE;
    p = 2'd0;
    k = d0[2:0];
    vop_lookup = 1'b0;
    if (d0 <= 12'(DAG_VOP_PLAIN)) begin
      vop_lookup = 1'b1;
    end else if (d1 <= 12'(DAG_VOP_PLAIN)) begin
      p = 2'd1;
      k = d1[2:0];
      vop_lookup = 1'b1;
    end else if (d2 <= 12'(DAG_VOP_PLAIN)) begin
      p = 2'd2;
      k = d2[2:0];
      vop_lookup = 1'b1;
    end
  endfunction : vop_lookup

  // Only operand-carrying requests arrive here; inherent and literal
  // instructions never raise one, so they act the same in both sets
  assign take = i_req_valid && (state_reg == DAG_ST_IDLE);
  assign o_req_ready = (state_reg == DAG_ST_IDLE);
  // W-indexed offset, sign extended to the address width
  assign sw_w = {{4{i_w_reg[7]}}, i_w_reg};

  // First stage: the address the instruction operand names
  always_comb begin
    if (i_acc_sel) begin
      dir_addr = {bank_reg, i_file_op};
      dir_mode = DAG_MODE_BANKED;
    end else if (xset_reg && (i_file_op <= DAG_LITOFF_MAX)) begin
      // Unsigned offset, sum wraps inside the data space
      dir_addr = ptr_reg[2] + {4'h0, i_file_op};
      dir_mode = DAG_MODE_LITOFF;
    end else if (i_file_op > DAG_LITOFF_MAX) begin
      dir_addr = {DAG_FORCED_PAGE, i_file_op};
      dir_mode = DAG_MODE_FORCED;
    end else begin
      dir_addr = {DAG_LOW_PAGE, i_file_op};
      dir_mode = DAG_MODE_LOWACC;
    end
  end

  // Second stage: dereference when the named address is a virtual operand
  always_comb begin
    dir_virt = vop_lookup(dir_addr, dir_pair, dir_vop);
    eff_addr = dir_addr;
    eff_mode = dir_mode;
    if (dir_virt) begin
      eff_mode = DAG_MODE_INDIRECT;
      unique case (dir_vop)
        DAG_VOP_PRE_UP: eff_addr = ptr_reg[dir_pair] + 12'h001;
        DAG_VOP_WIDX: eff_addr = ptr_reg[dir_pair] + sw_w;
        default: eff_addr = ptr_reg[dir_pair];
      endcase
    end
  end

  // A pointer aimed at another virtual operand is a dead target
  always_comb begin
    logic [1:0] np;
    logic [2:0] nk;
    np = 2'd0;
    nk = 3'd0;
    eff_null = dir_virt && vop_lookup(eff_addr, np, nk);
  end

  // Registers inside the block that answer directly
  always_comb begin
    loc_hit = 1'b1;
    loc_rdata = DAG_NULL_READ;
    unique case (eff_addr)
      DAG_PTR0_LOW_ADDR: loc_rdata = ptr_reg[0][7:0];
      DAG_PTR0_HIGH_ADDR: loc_rdata = {4'h0, ptr_reg[0][11:8]};
      DAG_PTR1_LOW_ADDR: loc_rdata = ptr_reg[1][7:0];
      DAG_PTR1_HIGH_ADDR: loc_rdata = {4'h0, ptr_reg[1][11:8]};
      DAG_PTR2_LOW_ADDR: loc_rdata = ptr_reg[2][7:0];
      DAG_PTR2_HIGH_ADDR: loc_rdata = {4'h0, ptr_reg[2][11:8]};
      DAG_BANK_SEL_ADDR: loc_rdata = {4'h0, bank_reg};
      default: loc_hit = 1'b0;
    endcase
    if (eff_null) begin
      loc_hit = 1'b1;
      loc_rdata = DAG_NULL_READ;
    end
  end

  // Next value of each pointer pair; a write that lands on a pair's own
  // bytes wins over that pair's automatic step
  generate
    for (genvar n = 0; n < DAG_NPTR; n++) begin : g_ptr
      localparam logic [11:0] LO_A = (n == 0) ? DAG_PTR0_LOW_ADDR : (n == 1) ? DAG_PTR1_LOW_ADDR : DAG_PTR2_LOW_ADDR;
      localparam logic [11:0] HI_A = (n == 0) ? DAG_PTR0_HIGH_ADDR : (n == 1) ? DAG_PTR1_HIGH_ADDR : DAG_PTR2_HIGH_ADDR;
      always_comb begin
        ptr_next[n] = ptr_reg[n];
        if (take && dir_virt && !eff_null && (dir_pair == 2'(n))) begin
          // Whole-pair arithmetic so the low byte carries into the high
          unique case (dir_vop)
            DAG_VOP_POST_UP: ptr_next[n] = ptr_reg[n] + 12'h001;
            DAG_VOP_POST_DOWN: ptr_next[n] = ptr_reg[n] - 12'h001;
            DAG_VOP_PRE_UP: ptr_next[n] = ptr_reg[n] + 12'h001;
            default: ptr_next[n] = ptr_reg[n];
          endcase
        end
        if (take && i_req_write && !eff_null) begin
          if (eff_addr == LO_A) begin
            ptr_next[n] = {ptr_reg[n][11:8], i_req_wdata};
          end else if (eff_addr == HI_A) begin
            ptr_next[n] = {i_req_wdata[3:0], ptr_reg[n][7:0]};
          end
        end
      end
    end
  endgenerate

  // APB decode signals
  logic apb_wr;
  logic apb_setup_rd;
  logic apb_mapped;
  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_setup_rd = i_psel && !i_penable && !i_pwrite;
  // Offsets that exist; anything else is refused with a slave error
  always_comb begin
    unique case (i_paddr)
      DAG_OFS_PTR0, DAG_OFS_PTR1, DAG_OFS_PTR2, DAG_OFS_BANK, DAG_OFS_CTRL, DAG_OFS_STATUS: apb_mapped = 1'b1;
      default: apb_mapped = 1'b0;
    endcase
  end

  // Pointer storage; status flags live elsewhere and are never driven here
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (int n = 0; n < DAG_NPTR; n++) begin
        ptr_reg[n] <= DAG_PTR_RST;
      end
    end else begin
      for (int n = 0; n < DAG_NPTR; n++) begin
        ptr_reg[n] <= ptr_next[n];
      end
      // Core traffic has priority; an APB write in the same cycle yields
      // APB carries a whole word, but only 12 bits exist to take it
      if (apb_wr && !take) begin
        if (i_paddr == DAG_OFS_PTR0) begin
          ptr_reg[0] <= i_pwdata[11:0];
        end
        if (i_paddr == DAG_OFS_PTR1) begin
          ptr_reg[1] <= i_pwdata[11:0];
        end
        if (i_paddr == DAG_OFS_PTR2) begin
          ptr_reg[2] <= i_pwdata[11:0];
        end
      end
    end
  end

  // Bank select register, reachable from the core and from APB
  // The core's write wins over an APB write landing in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bank_reg <= DAG_BANK_RST;
    end else if (take && i_req_write && !eff_null && (eff_addr == DAG_BANK_SEL_ADDR)) begin
      bank_reg <= i_req_wdata[3:0];
    end else if (apb_wr && (i_paddr == DAG_OFS_BANK)) begin
      bank_reg <= i_pwdata[3:0];
    end
  end

  // Extended-set enable; changing it mid-request is not meaningful
  // Software sets it before use; there is no handshake with a request in flight
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      xset_reg <= DAG_XSET_RST;
    end else if (apb_wr && (i_paddr == DAG_OFS_CTRL)) begin
      xset_reg <= i_pwdata[DAG_CTRL_XSET_BIT];
    end
  end

  // Request sequencer: issue, memory latency, answer
  // One request outstanding; ready returns only with the answer slot
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_reg <= DAG_ST_IDLE;
    end else begin
      unique case (state_reg)
        DAG_ST_IDLE: state_reg <= take ? DAG_ST_ISSUE : DAG_ST_IDLE;
        DAG_ST_ISSUE: state_reg <= DAG_ST_CAPT;
        DAG_ST_CAPT: state_reg <= DAG_ST_IDLE;
        default: state_reg <= DAG_ST_IDLE;
      endcase
    end
  end

  // Memory strobes stand one cycle; local and dead targets issue none
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_mem_addr <= 12'h000;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_wdata <= 8'h00;
    end else begin
      o_mem_rd <= take && !i_req_write && !loc_hit;
      o_mem_wr <= take && i_req_write && !loc_hit;
      if (take) begin
        o_mem_addr <= eff_addr;
        o_mem_wdata <= i_req_wdata;
      end
    end
  end

  // Read source remembered from the taken request
  // Local bytes are frozen at take time so a later pointer step cannot leak in
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rd_src_mem_reg <= 1'b0;
      rd_local_reg <= 8'h00;
      mode_reg <= DAG_MODE_BANKED;
      last_addr_reg <= 12'h000;
    end else if (take) begin
      rd_src_mem_reg <= !loc_hit;
      rd_local_reg <= loc_rdata;
      mode_reg <= eff_null ? DAG_MODE_NULL : eff_mode;
      last_addr_reg <= eff_addr;
    end
  end

  // Answer to the core, one-cycle done pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_done <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_done <= (state_reg == DAG_ST_CAPT);
      if (state_reg == DAG_ST_CAPT) begin
        o_rdata <= rd_src_mem_reg ? i_mem_rdata : rd_local_reg;
      end
    end
  end

  // APB read data captured in the setup cycle; zero wait states
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup_rd) begin
      unique case (i_paddr)
        DAG_OFS_PTR0: o_prdata <= {20'h00000, ptr_reg[0]};
        DAG_OFS_PTR1: o_prdata <= {20'h00000, ptr_reg[1]};
        DAG_OFS_PTR2: o_prdata <= {20'h00000, ptr_reg[2]};
        DAG_OFS_BANK: o_prdata <= {28'h0000000, bank_reg};
        DAG_OFS_CTRL: o_prdata <= {31'h0, xset_reg};
        DAG_OFS_STATUS: o_prdata <= {13'h0, state_reg, mode_reg, 2'b00, last_addr_reg};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Every register answers at once, so the bus never waits
  assign o_pready = 1'b1;
  // Unmapped offsets answer with an error in the access phase
  assign o_pslverr = i_psel && i_penable && !apb_mapped;

endmodule : dag_address_gen

// File: verilog/dag_pkg.sv
package dag_pkg;

  // Data space geometry
  localparam int DAG_AW = 12;
  localparam int DAG_NPTR = 3;

  // Pointer pair byte addresses in the special-function area
  localparam logic [11:0] DAG_PTR0_LOW_ADDR = 12'hFE9;
  localparam logic [11:0] DAG_PTR0_HIGH_ADDR = 12'hFEA;
  localparam logic [11:0] DAG_PTR1_LOW_ADDR = 12'hFE1;
  localparam logic [11:0] DAG_PTR1_HIGH_ADDR = 12'hFE2;
  localparam logic [11:0] DAG_PTR2_LOW_ADDR = 12'hFD9;
  localparam logic [11:0] DAG_PTR2_HIGH_ADDR = 12'hFDA;
  localparam logic [11:0] DAG_BANK_SEL_ADDR = 12'hFE0;

  // Virtual operand blocks: base is the w-indexed operand, then
  // pre-increment, post-decrement, post-increment, plain dereference
  localparam logic [11:0] DAG_VIRT0_BASE = 12'hFEB;
  localparam logic [11:0] DAG_VIRT1_BASE = 12'hFE3;
  localparam logic [11:0] DAG_VIRT2_BASE = 12'hFDB;
  localparam logic [11:0] DAG_POINTER1_DEREF_OPERAND = 12'hFE7;
  localparam logic [2:0] DAG_VOP_WIDX = 3'h0;
  localparam logic [2:0] DAG_VOP_PRE_UP = 3'h1;
  localparam logic [2:0] DAG_VOP_POST_DOWN = 3'h2;
  localparam logic [2:0] DAG_VOP_POST_UP = 3'h3;
  localparam logic [2:0] DAG_VOP_PLAIN = 3'h4;

  // Access bank split and direct-forced page
  localparam logic [7:0] DAG_LITOFF_MAX = 8'h5F;
  localparam logic [3:0] DAG_FORCED_PAGE = 4'hF;
  localparam logic [3:0] DAG_LOW_PAGE = 4'h0;
  localparam logic [7:0] DAG_NULL_READ = 8'h00;

  // APB register byte offsets
  localparam logic [7:0] DAG_OFS_PTR0 = 8'h00;
  localparam logic [7:0] DAG_OFS_PTR1 = 8'h04;
  localparam logic [7:0] DAG_OFS_PTR2 = 8'h08;
  localparam logic [7:0] DAG_OFS_BANK = 8'h0C;
  localparam logic [7:0] DAG_OFS_CTRL = 8'h10;
  localparam logic [7:0] DAG_OFS_STATUS = 8'h14;
  localparam int DAG_CTRL_XSET_BIT = 0;

  // Reset values
  localparam logic [11:0] DAG_PTR_RST = 12'h000;
  localparam logic [3:0] DAG_BANK_RST = 4'h0;
  localparam logic DAG_XSET_RST = 1'b0;

  // Addressing mode of the last taken request
  typedef enum logic [2:0] {
    DAG_MODE_BANKED = 3'h0,
    DAG_MODE_FORCED = 3'h1,
    DAG_MODE_LOWACC = 3'h2,
    DAG_MODE_LITOFF = 3'h3,
    DAG_MODE_INDIRECT = 3'h4,
    DAG_MODE_NULL = 3'h5
  } dag_mode_t;

  // Request sequencer, Gray up to CAPT; CAPT back to IDLE flips both bits
  typedef enum logic [1:0] {
    DAG_ST_IDLE = 2'b00,
    DAG_ST_ISSUE = 2'b01,
    DAG_ST_CAPT = 2'b11
  } dag_state_t;

endpackage : dag_pkg
